/* File: sfb_bit_ops.v */
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "sfb_defs.vh"

// Notes on behaviour
// RULE_01 - Nibble exchange swaps the two halves of the named working register, leaves flags alone, one cycle.
// RULE_02 - Set or clear status bit forces the operand-selected status bit to one or zero in one cycle.
// RULE_03 - Store bit to transfer copies the selected source register bit into the transfer flag in one cycle.
// RULE_04 - Load bit from transfer copies the transfer flag into the selected register bit, flags untouched.
// RULE_05 - Carry ops set or clear only the carry flag in one cycle.
// RULE_06 - Negative ops set or clear the negative flag in one cycle.
// RULE_07 - Zero ops set or clear the zero flag in one cycle.
// RULE_08 - Interrupt enable and disable set or clear the global interrupt flag in one cycle.
// RULE_09 - Sign ops set or clear the signed test flag in one cycle.
// RULE_10 - Overflow ops set or clear the overflow flag in one cycle.
// RULE_11 - Transfer ops set or clear the transfer flag in one cycle.
// RULE_12 - Half-carry ops set or clear the half-carry flag in one cycle.
// RULE_13 - Bit selectors are three-bit indices and every flag not addressed keeps its value.
module sfb_bit_ops #(
  parameter NREGS = 32,
  parameter RAW   = 5
) (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  // AXI4-Lite write data
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  // AXI4-Lite read address
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  input  wire [31:0] s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  // AXI4-Lite read data
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  // Status flags to the core
  output reg  [7:0]  status_register
);

  // ----------------------------------------------------------------
  // Write channel capture
  // ----------------------------------------------------------------
  reg        aw_held;
  reg [4:0]  aw_addr;
  reg        w_held;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  wire       wr_go;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_go         = aw_held && w_held && !s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 5'h00;
      w_held  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr[4:0];
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  wire hit_cmd    = (aw_addr == {1'b0, `SFB_OFF_CMD});
  wire hit_status = (aw_addr == {1'b0, `SFB_OFF_STATUS});
  wire hit_sel    = (aw_addr == {1'b0, `SFB_OFF_WREG_SEL});
  wire hit_data   = (aw_addr == {1'b0, `SFB_OFF_WREG_DATA});
  wire hit_info   = (aw_addr == `SFB_OFF_INFO);
  wire wr_mapped  = hit_cmd || hit_status || hit_sel || hit_data || hit_info;
  wire cmd_go     = wr_go && hit_cmd && (w_strb[2:0] == 3'b111);

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SFB_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? `SFB_RESP_OKAY : `SFB_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Command and window select registers
  // ----------------------------------------------------------------
  reg [31:0]    cmd_word;
  reg [RAW-1:0] wreg_sel;
  reg           exec_pend;
  reg [4:0]     exec_op;
  reg [RAW-1:0] exec_reg;
  reg [2:0]     exec_bit;

  always @(posedge aclk) begin
    if (!aresetn) begin
      cmd_word  <= `SFB_CMD_RST;
      wreg_sel  <= `SFB_WREG_SEL_RST;
      exec_pend <= 1'b0;
      exec_op   <= `SFB_OP_NOP;
      exec_reg  <= {RAW{1'b0}};
      exec_bit  <= 3'd0;
    end else begin
      exec_pend <= cmd_go;
      if (cmd_go) begin
        cmd_word <= w_data;
        exec_op  <= w_data[`SFB_CMD_OP_MSB:`SFB_CMD_OP_LSB];
        exec_reg <= w_data[`SFB_CMD_REG_LSB+RAW-1:`SFB_CMD_REG_LSB];
        exec_bit <= w_data[`SFB_CMD_BIT_MSB:`SFB_CMD_BIT_LSB]; // RULE_13
      end
      if (wr_go && hit_sel && w_strb[0]) begin
        wreg_sel <= w_data[RAW-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Working register file
  // ----------------------------------------------------------------
  reg           rf_wr_en;
  reg [RAW-1:0] rf_wr_addr;
  reg [7:0]     rf_wr_data;
  wire [RAW-1:0] rf_rd_addr;
  wire [7:0]     rf_rd_data;

  assign rf_rd_addr = cmd_go ? w_data[`SFB_CMD_REG_LSB+RAW-1:`SFB_CMD_REG_LSB] : wreg_sel;

  sfb_regfile #(
    .DW    (8),
    .DEPTH (NREGS),
    .AW    (RAW)
  ) u_regfile (
    .aclk    (aclk),
    .wr_en   (rf_wr_en),
    .wr_addr (rf_wr_addr),
    .wr_data (rf_wr_data),
    .rd_addr (rf_rd_addr),
    .rd_data (rf_rd_data)
  );

  // ----------------------------------------------------------------
  // Execute stage
  // ----------------------------------------------------------------
  wire       op_flag   = exec_op[`SFB_OP_FLAG_BIT];
  wire [2:0] flag_idx  = exec_op[`SFB_OP_FLAG_MSB:`SFB_OP_FLAG_LSB];
  wire       flag_val  = exec_op[`SFB_OP_FLAG_VAL];
  wire       op_known  = op_flag || (exec_op <= `SFB_OP_LOAD_T);
  reg        st_hit;
  reg [2:0]  st_idx;
  reg        st_val;

  always @* begin
    st_hit     = 1'b0;
    st_idx     = 3'd0;
    st_val     = 1'b0;
    rf_wr_en   = 1'b0;
    rf_wr_addr = wreg_sel;
    rf_wr_data = w_data[7:0];
    if (exec_pend) begin
      rf_wr_addr = exec_reg;
      if (op_flag) begin
        st_hit = 1'b1; // RULE_05 RULE_06 RULE_07 RULE_08
        st_idx = flag_idx; // RULE_09 RULE_10 RULE_11 RULE_12
        st_val = flag_val;
      end else begin
        case (exec_op)
          `SFB_OP_SWAP: begin
            rf_wr_en   = 1'b1;
            rf_wr_data = {rf_rd_data[3:0], rf_rd_data[7:4]}; // RULE_01
          end
          `SFB_OP_SET_STATUS: begin
            st_hit = 1'b1;
            st_idx = exec_bit;
            st_val = 1'b1; // RULE_02
          end
          `SFB_OP_CLR_STATUS: begin
            st_hit = 1'b1;
            st_idx = exec_bit;
            st_val = 1'b0; // RULE_02
          end
          `SFB_OP_STORE_T: begin
            st_hit = 1'b1;
            st_idx = `SFB_FLAG_T;
            st_val = rf_rd_data[exec_bit]; // RULE_03
          end
          `SFB_OP_LOAD_T: begin
            rf_wr_en   = 1'b1;
            rf_wr_data = rf_rd_data;
            rf_wr_data[exec_bit] = status_register[`SFB_FLAG_T]; // RULE_04
          end
          default: begin
            st_hit = 1'b0;
          end
        endcase
      end
    end else if (wr_go && hit_data && w_strb[0]) begin
      rf_wr_en = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Status register, one flop per flag
  // ----------------------------------------------------------------
  wire       sw_status = wr_go && hit_status && w_strb[0];
  wire [7:0] next_status;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag
      assign next_status[gi] = (st_hit && (st_idx == gi)) ? st_val :
                               sw_status ? w_data[gi] : status_register[gi]; // RULE_13
    end
  endgenerate

  always @(posedge aclk) begin
    if (!aresetn) begin
      status_register <= `SFB_STATUS_RST;
    end else begin
      status_register <= next_status;
    end
  end

  // ----------------------------------------------------------------
  // Unknown opcode flag, set wins over clear
  // ----------------------------------------------------------------
  reg  bad_op;
  wire bad_op_set = exec_pend && !op_known;
  wire bad_op_clr = wr_go && hit_info && w_strb[0] && w_data[`SFB_INFO_BAD_OP];

  always @(posedge aclk) begin
    if (!aresetn) begin
      bad_op <= 1'b0;
    end else if (bad_op_set) begin
      bad_op <= 1'b1;
    end else if (bad_op_clr) begin
      bad_op <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  reg        ar_wait;
  reg [4:0]  ar_addr;
  reg [31:0] rd_mux;
  reg        rd_ok;

  assign s_axi_arready = !s_axi_rvalid && !ar_wait && !exec_pend && !cmd_go;

  always @* begin
    rd_mux = 32'h0000_0000;
    rd_ok  = 1'b1;
    case (ar_addr)
      {1'b0, `SFB_OFF_CMD}:       rd_mux = cmd_word;
      {1'b0, `SFB_OFF_STATUS}:    rd_mux = {24'h00_0000, status_register};
      {1'b0, `SFB_OFF_WREG_SEL}:  rd_mux[RAW-1:0] = wreg_sel;
      {1'b0, `SFB_OFF_WREG_DATA}: rd_mux = {24'h00_0000, rf_rd_data};
      `SFB_OFF_INFO: begin
        rd_mux[`SFB_INFO_BUSY]   = exec_pend;
        rd_mux[`SFB_INFO_BAD_OP] = bad_op;
      end
      default:                    rd_ok  = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      ar_wait      <= 1'b0;
      ar_addr      <= 5'h00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `SFB_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        ar_wait <= 1'b1;
        ar_addr <= s_axi_araddr[4:0];
      end else if (ar_wait) begin
        ar_wait      <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_ok ? `SFB_RESP_OKAY : `SFB_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // sfb_bit_ops

/* File: sfb_defs.vh */
`ifndef SFB_DEFS_VH
`define SFB_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SFB_OFF_CMD        4'h0
`define SFB_OFF_STATUS     4'h4
`define SFB_OFF_WREG_SEL   4'h8
`define SFB_OFF_WREG_DATA  4'hC
`define SFB_OFF_INFO       5'h10

// ----------------------------------------------------------------
// Command word fields
// ----------------------------------------------------------------
`define SFB_CMD_OP_LSB     0
`define SFB_CMD_OP_MSB     4
`define SFB_CMD_REG_LSB    8
`define SFB_CMD_REG_MSB    12
`define SFB_CMD_BIT_LSB    16
`define SFB_CMD_BIT_MSB    18

// ----------------------------------------------------------------
// Opcodes; bit 4 set means dedicated flag op: [3:1] flag, [0] value
// ----------------------------------------------------------------
`define SFB_OP_NOP         5'h00
`define SFB_OP_SWAP        5'h01
`define SFB_OP_SET_STATUS  5'h02
`define SFB_OP_CLR_STATUS  5'h03
`define SFB_OP_STORE_T     5'h04
`define SFB_OP_LOAD_T      5'h05
`define SFB_OP_FLAG_BIT    4
`define SFB_OP_FLAG_LSB    1
`define SFB_OP_FLAG_MSB    3
`define SFB_OP_FLAG_VAL    0

// ----------------------------------------------------------------
// Status register bit positions
// ----------------------------------------------------------------
`define SFB_FLAG_C         3'd0
`define SFB_FLAG_Z         3'd1
`define SFB_FLAG_N         3'd2
`define SFB_FLAG_V         3'd3
`define SFB_FLAG_S         3'd4
`define SFB_FLAG_H         3'd5
`define SFB_FLAG_T         3'd6
`define SFB_FLAG_I         3'd7

// ----------------------------------------------------------------
// Info register fields, reset values, responses, timing
// ----------------------------------------------------------------
`define SFB_INFO_BUSY      0
`define SFB_INFO_BAD_OP    1
`define SFB_STATUS_RST     8'h00
`define SFB_CMD_RST        32'h0000_0000
`define SFB_WREG_SEL_RST   5'h00
`define SFB_RESP_OKAY      2'h0
`define SFB_RESP_SLVERR    2'h2
`define SFB_EXEC_CYCLES    1

`endif

/* File: sfb_regfile.v */
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Working register file, registered read port
// ----------------------------------------------------------------
module sfb_regfile #(
  parameter DW    = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  // Clock
  input  wire          aclk,
  // Write port
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [DW-1:0] wr_data,
  // Read port
  input  wire [AW-1:0] rd_addr,
  output reg  [DW-1:0] rd_data
);

  reg [DW-1:0] mem [0:DEPTH-1];

  always @(posedge aclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule // sfb_regfile

/* File: sfb_bit_ops_assertions.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module sfb_chk (
  // Clock and reset
  input wire        aclk,
  input wire        aresetn,
  // Write side
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [31:0] s_axi_awaddr,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0]  s_axi_wstrb,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  // Read side
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  // Flags
  input wire [7:0]  status_register
);
  reg  [19:0] p1, p2, p3;
  wire        hs_w = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire        go   = hs_w && s_axi_awaddr[4:0] == 5'h00 && s_axi_wstrb[2:0] == 3'h7;
  wire        ex   = p3[19];
  wire [4:0]  op   = p3[4:0];
  wire [7:0]  fm   = 8'h01 << p3[3:1];
  wire [7:0]  bm   = 8'h01 << p3[18:16];

  // Command word delayed to the sample after its execute edge
  always @(posedge aclk) begin
    if (!aresetn) begin
      p1 <= 20'h0_0000;
      p2 <= 20'h0_0000;
      p3 <= 20'h0_0000;
    end else begin
      p1 <= {go, s_axi_wdata[18:0]};
      p2 <= p1;
      p3 <= p2;
    end
  end

  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence b_rise; !s_axi_bvalid ##1 s_axi_bvalid; endsequence
  sequence r_rise; !s_axi_rvalid ##1 s_axi_rvalid; endsequence

  chk_flag_value:
    assert property (ex && op[4] |-> status_register[p3[3:1]] == op[0]) else $error("flag op value");
  chk_flag_others:
    assert property (ex && op[4] |-> ((status_register ^ $past(status_register)) & ~fm) == 8'h00)
      else $error("flag op touched other flags");
  chk_set_bit:
    assert property (ex && op == 5'h02 |-> status_register == ($past(status_register) | bm)) else $error("set bit");
  chk_clr_bit:
    assert property (ex && op == 5'h03 |-> status_register == ($past(status_register) & ~bm)) else $error("clr bit");
  chk_keep_flags:
    assert property (ex && (op == 5'h01 || op == 5'h05) |-> $stable(status_register)) else $error("flags moved");
  chk_store_t_only:
    assert property (ex && op == 5'h04 |-> ((status_register ^ $past(status_register)) & 8'hbf) == 8'h00)
      else $error("store touched non-transfer flags");
  chk_other_keep:
    assert property (ex && !op[4] && (op == 5'h00 || op > 5'h05) |-> $stable(status_register))
      else $error("no-op touched flags");
  chk_b_timing:
    assert property (hs_w |=> b_rise) else $error("write answer timing");
  chk_b_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b hold");
  chk_r_timing:
    assert property (s_axi_arvalid && s_axi_arready |=> r_rise) else $error("read answer timing");
endmodule // sfb_chk

bind sfb_bit_ops sfb_chk i_sfb_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
  .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .status_register);

/* File: tb.sv */
`timescale 1ns/10ps
module tb;
  reg         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg  [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr;
  reg  [3:0]  s_axi_wstrb;
  reg  [2:0]  s_axi_awprot, s_axi_arprot;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0]  status_register;
  integer     n_errors, checks_done, cyc, seed, k;
  reg  [33:0] rq[$];
  reg  [1:0]  bq[$];
  reg  [7:0]  st, d;
  reg  [4:0]  ri;

  sfb_bit_ops i_sfb_bit_ops (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .status_register);

  initial begin
    aclk = 0;
    forever #25 aclk = ~aclk;
  end

  // ----------------------------------------------------------------
  // Compare, close, monitor
  // ----------------------------------------------------------------
  task chk(input string nm, input [33:0] s, input [33:0] e);
    checks_done = checks_done + 1;
    if (s !== e) begin
      n_errors = n_errors + 1;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) chk("rdata", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid && s_axi_bready) chk("bresp", {32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
    cyc = cyc + 1;
    if (cyc > 6000) begin
      n_errors = n_errors + 1;
      close_out;
    end
  end

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task wr(input [31:0] a, input [31:0] dt, input [1:0] e);
    reg aw_hs, w_hs;
    bq.push_back(e);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= dt;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    // Each channel released at its own handshake edge
    @(negedge aclk);
    while (s_axi_awvalid || s_axi_wvalid) begin
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs  = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (aw_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
      @(negedge aclk);
    end
    @(posedge aclk);
    repeat ($random(seed) & 3) @(posedge aclk);
    s_axi_bready <= 1'b1;
    @(negedge aclk);
    while (!s_axi_bvalid) @(negedge aclk);
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask

  task rd(input [31:0] a, input [33:0] e);
    rq.push_back(e);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    @(negedge aclk);
    while (!s_axi_arready) @(negedge aclk);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    repeat ($random(seed) & 3) @(posedge aclk);
    s_axi_rready <= 1'b1;
    @(negedge aclk);
    while (!s_axi_rvalid) @(negedge aclk);
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask

  task cmd(input [4:0] op, input [4:0] rg, input [2:0] b);
    wr(32'h0000_0000, {13'h0, b, 3'h0, rg, 3'h0, op}, 2'h0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 1938;
    n_errors = 0;
    checks_done = 0;
    cyc = 0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    {s_axi_awprot, s_axi_arprot} = 6'h00;
    s_axi_wstrb = 4'hf;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(32'h0000_0004, 34'h0);
    rd(32'h0000_0000, 34'h0);
    $display("reset values done");
    for (k = 0; k < 16; k = k + 1) begin
      st = 8'($random(seed));
      st[k >> 1] = !k[0];
      wr(32'h0000_0004, {24'h0, st}, 2'h0);
      st[k >> 1] = k[0];
      cmd(5'h10 | k[4:0], 5'h00, 3'h0);
      rd(32'h0000_0004, {26'h0, st});
      st = 8'($random(seed));
      st[k[2:0]] = k[3];
      wr(32'h0000_0004, {24'h0, st}, 2'h0);
      st[k[2:0]] = !k[3];
      cmd(5'h02 + k[3], 5'h00, k[2:0]);
      rd(32'h0000_0004, {26'h0, st});
      // Flag pins looked at away from the clock edge
      @(negedge aclk);
      chk("status pins", {26'h0, status_register}, {26'h0, st});
      @(posedge aclk);
    end
    $display("flag ops done");
    ri = 5'd3;
    for (k = 0; k < 8; k = k + 1) begin
      d = 8'($random(seed));
      st = 8'($random(seed));
      wr(32'h0000_0008, {27'h0, ri}, 2'h0);
      wr(32'h0000_000c, {24'h0, d}, 2'h0);
      wr(32'h0000_0004, {24'h0, st}, 2'h0);
      rd(32'h0000_0008, {29'h0, ri});
      cmd(5'h01, ri, 3'h0);
      d = {d[3:0], d[7:4]};
      rd(32'h0000_000c, {26'h0, d});
      rd(32'h0000_0004, {26'h0, st});
      cmd(5'h04, ri, k[2:0]);
      st[6] = d[k];
      rd(32'h0000_0004, {26'h0, st});
      st[6] = !st[6];
      wr(32'h0000_0004, {24'h0, st}, 2'h0);
      cmd(5'h05, ri, k[2:0]);
      d[k] = st[6];
      rd(32'h0000_000c, {26'h0, d});
      rd(32'h0000_0004, {26'h0, st});
      ri = ri + 5'd5;
    end
    $display("register bit ops done");
    // Unknown opcode: sticky flag, flags kept, write one clears
    st = 8'($random(seed)) & 8'hfe;
    wr(32'h0000_0004, {24'h0, st}, 2'h0);
    cmd(5'h07, 5'h00, 3'h0);
    rd(32'h0000_0010, 34'h0_0000_0002);
    rd(32'h0000_0004, {26'h0, st});
    wr(32'h0000_0010, 32'h0000_0002, 2'h0);
    rd(32'h0000_0010, 34'h0_0000_0000);
    // Command with partial strobes is ignored
    s_axi_wstrb <= 4'h3;
    cmd(5'h11, 5'h00, 3'h0);
    s_axi_wstrb <= 4'hf;
    rd(32'h0000_0004, {26'h0, st});
    rd(32'h0000_0000, 34'h0_0000_0007);
    $display("opcode and strobe checks done");
    wr(32'h0000_0014, 32'h0000_00ff, 2'h2);
    rd(32'h0000_0014, {2'h2, 32'h0});
    $display("unmapped access done");
    close_out;
  end
endmodule // tb
